/* src/crr_cfg.svh */
// register indices, field positions and reset values of the reflection result bank
// assumes byte address = 4 * index on a 32-bit register bus
`ifndef CRR_CFG_SVH
`define CRR_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CRR_IDX_A01 10'h190
`define CRR_IDX_A23 10'h191
`define CRR_IDX_A4B0 10'h192
`define CRR_IDX_B12 10'h193
`define CRR_IDX_B34 10'h194
`define CRR_IDX_C01 10'h195
`define CRR_IDX_C23 10'h196
`define CRR_IDX_C4D0 10'h197
`define CRR_IDX_D12 10'h198
`define CRR_IDX_D34 10'h199
`define CRR_IDX_STATUS 10'h1A4
`define CRR_IDX_CTRL 10'h1B0
`define CRR_IDX_IRQ_STAT 10'h1B1
`define CRR_IDX_IRQ_EN 10'h1B2
`define CRR_IDX_IRQ_CLR 10'h1B3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CRR_ST_CROSS_LSB 8
`define CRR_ST_FULL_LSB 4
`define CRR_ST_HIGH_LSB 0
`define CRR_CTRL_XDIS_BIT 0
`define CRR_EV_DONE 0
`define CRR_EV_FULL 1
`define CRR_EV_HIGH 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRR_RST_POS 8'h00
`define CRR_RST_STATUS 12'h000
`define CRR_RST_CTRL 1'b0
`define CRR_RST_IRQ 3'h0

`endif

/* src/crr_pkg.sv */
// types shared by the reflection result bank and its bus front end
// assumes the constants of crr_cfg.svh for all numbers
package crr_pkg;

	typedef logic [7:0] crr_pos_t;
	typedef logic [9:0] crr_idx_t;
	typedef logic [31:0] crr_word_t;

	// axi response codes
	typedef enum logic [1:0] {
		CRR_RESP_OKAY = 2'b00,
		CRR_RESP_SLVERR = 2'b10
	} crr_resp_e;

endpackage

/* src/crr_axil_slv.sv */
// axi4-lite slave front end: one read in flight at most; a second write may be accepted while a write response waits
// assumes the register file answers rd_data/rd_hit/wr_hit combinationally
`timescale 1ns/100ps

module crr_axil_slv
	import crr_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wr_en,
	output crr_idx_t wr_idx,
	output crr_word_t wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	output crr_idx_t rd_idx,
	input wire crr_word_t rd_data,
	input wire logic rd_hit
);

	logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
	crr_idx_t aw_idx_r, aw_idx_nxt;
	crr_word_t w_data_r, w_data_nxt, rdata_r, rdata_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
	crr_resp_e bresp_r, bresp_nxt, rresp_r, rresp_nxt;

	// address and data are held separately so they may arrive in either order
	always_comb begin
		wr_en = aw_full_r && w_full_r && !bvalid_r;
		wr_idx = aw_idx_r;
		wr_data = w_data_r;
		wr_strb = w_strb_r;
		rd_idx = s_araddr[11:2];
		aw_full_nxt = wr_en ? 1'b0 : (aw_full_r || (s_awvalid && awready_r));
		aw_idx_nxt = (s_awvalid && awready_r) ? s_awaddr[11:2] : aw_idx_r;
		w_full_nxt = wr_en ? 1'b0 : (w_full_r || (s_wvalid && wready_r));
		w_data_nxt = (s_wvalid && wready_r) ? s_wdata : w_data_r;
		w_strb_nxt = (s_wvalid && wready_r) ? s_wstrb : w_strb_r;
		bvalid_nxt = wr_en || (bvalid_r && !s_bready);
		bresp_nxt = wr_en ? (wr_hit ? CRR_RESP_OKAY : CRR_RESP_SLVERR) : bresp_r;
		awready_nxt = !aw_full_nxt;
		wready_nxt = !w_full_nxt;
		// read data is captured at the address handshake, answered next cycle
		rvalid_nxt = (s_arvalid && arready_r) || (rvalid_r && !s_rready);
		rdata_nxt = (s_arvalid && arready_r) ? rd_data : rdata_r;
		rresp_nxt = (s_arvalid && arready_r) ? (rd_hit ? CRR_RESP_OKAY : CRR_RESP_SLVERR)
			: rresp_r;
		arready_nxt = !rvalid_nxt;
	end

	// handshake state, frozen while ce is low
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			aw_full_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_full_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= CRR_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= CRR_RESP_OKAY;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else if (ce) begin
			aw_full_r <= aw_full_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_full_r <= w_full_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	assign s_awready = awready_r;
	assign s_wready = wready_r;
	assign s_bvalid = bvalid_r;
	assign s_bresp = bresp_r;
	assign s_arready = arready_r;
	assign s_rvalid = rvalid_r;
	assign s_rdata = rdata_r;
	assign s_rresp = rresp_r;

endmodule // crr_axil_slv

/* src/crr_top.sv */
// cable reflection result bank: peak locations of four pairs and the result flags
// assumes the measurement engine pulses meas_done with all results valid that cycle
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "crr_cfg.svh"

module crr_top
	import crr_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int NUM_PEAK = 5,
	parameter int POS_W = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic meas_done,
	input wire logic [NUM_CH*NUM_PEAK*POS_W-1:0] peak_pos_in,
	input wire logic [NUM_CH-1:0] cross_peak_in,
	input wire logic [NUM_CH-1:0] count_full_in,
	input wire logic [NUM_CH-1:0] first_seg_high_in,
	output logic cross_listen_disable,
	output logic irq
);

	localparam int NUM_POS = NUM_CH * NUM_PEAK;
	localparam int NUM_PAIR = NUM_POS / 2;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the register layout is fixed: four pairs, five peaks, byte wide
	if (NUM_CH != 4 || NUM_PEAK != 5 || POS_W != 8) begin : g_bad_cfg
		$error("crr_top supports only four channels, five peaks, 8-bit positions");
	end

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	logic wr_en, wr_hit, rd_hit;
	crr_idx_t wr_idx, rd_idx;
	crr_word_t wr_data, rd_data;
	logic [3:0] wr_strb;

	crr_axil_slv u_slv (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// ----------------------------------------------------------------
	// measurement results
	// ----------------------------------------------------------------
	// pos_r[k], k = channel*5 + peak index, channel A first
	crr_pos_t pos_r [NUM_POS];
	crr_pos_t pos_nxt [NUM_POS];
	logic [11:0] status_r, status_nxt;
	logic [NUM_CH-1:0] cross_gated;
	logic ctrl_xdis_r, ctrl_xdis_nxt;

	// everything loads on the same edge, so a read never straddles two runs
	always_comb begin
		cross_gated = cross_peak_in & {NUM_CH{~ctrl_xdis_r}};
		status_nxt = status_r;
		for (int k = 0; k < NUM_POS; k++) begin
			pos_nxt[k] = pos_r[k];
		end
		if (meas_done) begin
			for (int k = 0; k < NUM_POS; k++) begin
				pos_nxt[k] = peak_pos_in[k*POS_W +: POS_W];
			end
			status_nxt = {cross_gated, count_full_in, first_seg_high_in};
		end
	end

	// software has no write path into this group at all
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int k = 0; k < NUM_POS; k++) begin
				pos_r[k] <= `CRR_RST_POS;
			end
			status_r <= `CRR_RST_STATUS;
		end else if (ce) begin
			for (int k = 0; k < NUM_POS; k++) begin
				pos_r[k] <= pos_nxt[k];
			end
			status_r <= status_nxt;
		end
	end

	// ----------------------------------------------------------------
	// control and interrupt registers
	// ----------------------------------------------------------------
	logic [2:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt, irq_ev, irq_clr;
	logic irq_r, irq_nxt;

	// set beats clear: an event in the clearing cycle stays pending
	always_comb begin
		irq_ev = 3'h0;
		irq_ev[`CRR_EV_DONE] = meas_done;
		irq_ev[`CRR_EV_FULL] = meas_done && (|count_full_in);
		irq_ev[`CRR_EV_HIGH] = meas_done && (|first_seg_high_in);
		irq_clr = 3'h0;
		ctrl_xdis_nxt = ctrl_xdis_r;
		irq_en_nxt = irq_en_r;
		if (wr_en && wr_strb[0]) begin
			unique case (wr_idx)
				`CRR_IDX_CTRL: ctrl_xdis_nxt = wr_data[`CRR_CTRL_XDIS_BIT];
				`CRR_IDX_IRQ_EN: irq_en_nxt = wr_data[2:0];
				`CRR_IDX_IRQ_CLR: irq_clr = wr_data[2:0];
				default: irq_clr = 3'h0;
			endcase
		end
		irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
		irq_nxt = |(irq_stat_nxt & irq_en_nxt);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_xdis_r <= `CRR_RST_CTRL;
			irq_stat_r <= `CRR_RST_IRQ;
			irq_en_r <= `CRR_RST_IRQ;
			irq_r <= 1'b0;
		end else if (ce) begin
			ctrl_xdis_r <= ctrl_xdis_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_en_r <= irq_en_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign cross_listen_disable = ctrl_xdis_r;
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	// word i holds position 2i low and 2i+1 high; this one pattern gives
	// the A4/B0 and C4/D0 straddles without special cases
	logic [15:0] pair_word [NUM_PAIR];

	for (genvar i = 0; i < NUM_PAIR; i++) begin : g_pair
		assign pair_word[i] = {pos_r[2*i+1], pos_r[2*i]};
	end

	logic [3:0] pair_sel;

	always_comb begin
		pair_sel = 4'(rd_idx - `CRR_IDX_A01);
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		if (rd_idx >= `CRR_IDX_A01 && rd_idx <= `CRR_IDX_D34) begin
			rd_data = {16'h0000, pair_word[pair_sel]};
		end else begin
			unique case (rd_idx)
				`CRR_IDX_STATUS: rd_data = {20'h0_0000, status_r};
				`CRR_IDX_CTRL: rd_data = {31'h0000_0000, ctrl_xdis_r};
				`CRR_IDX_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat_r};
				`CRR_IDX_IRQ_EN: rd_data = {29'h0000_0000, irq_en_r};
				`CRR_IDX_IRQ_CLR: rd_data = 32'h0000_0000;
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// result registers accept writes silently; only unmapped words error
	always_comb begin
		wr_hit = (wr_idx >= `CRR_IDX_A01 && wr_idx <= `CRR_IDX_D34)
			|| wr_idx == `CRR_IDX_STATUS || wr_idx == `CRR_IDX_CTRL
			|| wr_idx == `CRR_IDX_IRQ_STAT || wr_idx == `CRR_IDX_IRQ_EN
			|| wr_idx == `CRR_IDX_IRQ_CLR;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_a01_layout: assert property (rd_idx == `CRR_IDX_A01 |->
		rd_data == {16'h0000, pos_r[1], pos_r[0]})
		else $error("channel A 0/1 word misplaced");

	a_a23_a4_layout: assert property ((rd_idx == `CRR_IDX_A23 |->
		rd_data[15:0] == {pos_r[3], pos_r[2]})
		and (rd_idx == `CRR_IDX_A4B0 |-> rd_data[7:0] == pos_r[4]))
		else $error("channel A 2/3/4 misplaced");

	a_b_layout: assert property ((rd_idx == `CRR_IDX_A4B0 |-> rd_data[15:8] == pos_r[5])
		and (rd_idx == `CRR_IDX_B12 |-> rd_data[15:0] == {pos_r[7], pos_r[6]})
		and (rd_idx == `CRR_IDX_B34 |-> rd_data[15:0] == {pos_r[9], pos_r[8]}))
		else $error("channel B word misplaced");

	a_c_layout: assert property ((rd_idx == `CRR_IDX_C01 |-> rd_data[15:0] == {pos_r[11], pos_r[10]})
		and (rd_idx == `CRR_IDX_C23 |-> rd_data[15:0] == {pos_r[13], pos_r[12]})
		and (rd_idx == `CRR_IDX_C4D0 |-> rd_data[7:0] == pos_r[14]))
		else $error("channel C word misplaced");

	a_d_layout: assert property ((rd_idx == `CRR_IDX_C4D0 |-> rd_data[15:8] == pos_r[15])
		and (rd_idx == `CRR_IDX_D12 |-> rd_data[15:0] == {pos_r[17], pos_r[16]})
		and (rd_idx == `CRR_IDX_D34 |-> rd_data[15:0] == {pos_r[19], pos_r[18]}))
		else $error("channel D word misplaced");

	a_pos_held: assert property (!(ce && meas_done) |=>
		$stable(pos_r[0]) && $stable(pos_r[9]) && $stable(pos_r[19]))
		else $error("peak location changed without a measurement");

	a_cross_flag: assert property (ce && meas_done && !ctrl_xdis_r |=>
		status_r[11:8] == $past(cross_peak_in))
		else $error("cross-mode flags not loaded");

	a_full_flag: assert property (ce && meas_done |=>
		status_r[7:4] == $past(count_full_in))
		else $error("peak count full flags not loaded");

	a_high_flag: assert property (ce && meas_done |=>
		status_r[3:0] == $past(first_seg_high_in))
		else $error("segment one high flags not loaded");

	a_status_rsvd: assert property (rd_idx == `CRR_IDX_STATUS |->
		rd_data[31:12] == 20'h0_0000 && rd_hit)
		else $error("status reserved bits not zero");

	a_cross_block: assert property (ce && meas_done && ctrl_xdis_r |=>
		status_r[11:8] == 4'h0 ##1 (status_r[11:8] == 4'h0 || $past(ce && meas_done)))
		else $error("cross-mode flag set while cross listening off");

	a_joint_load: assert property (ce && meas_done |=>
		pos_r[0] == $past(peak_pos_in[7:0]) && pos_r[19] == $past(peak_pos_in[159:152])
		&& status_r[7:0] == $past({count_full_in, first_seg_high_in}))
		else $error("results and flags not loaded together");

	a_irq_follow: assert property (ce && meas_done && irq_en_r[`CRR_EV_DONE] |=>
		irq_stat_r[`CRR_EV_DONE] ##1 (!ce || irq))
		else $error("done event did not raise interrupt");

	// ----------------------------------------------------------------
	// bus, interrupt and status checks
	// ----------------------------------------------------------------
	// the level output must agree with status and enable in every cycle
	a_irq_level: assert property (irq == (|(irq_stat_r & irq_en_r)))
		else $error("interrupt level disagrees with status and enable");

	// a pending bit only drops through the clear register
	a_irq_sticky: assert property (ce |=>
		(irq_stat_r & $past(irq_stat_r & ~irq_clr)) == $past(irq_stat_r & ~irq_clr))
		else $error("pending interrupt bit lost without a clear");

	a_irq_clear: assert property (ce && !meas_done |=> (irq_stat_r & $past(irq_clr)) == 3'h0)
		else $error("interrupt clear did not take effect");

	// set beats clear, so these hold even with a clear in the same cycle
	a_full_event: assert property (ce && meas_done && (|count_full_in) |=>
		irq_stat_r[`CRR_EV_FULL])
		else $error("count full event not latched");

	a_high_event: assert property (ce && meas_done && (|first_seg_high_in) |=>
		irq_stat_r[`CRR_EV_HIGH])
		else $error("segment one high event not latched");

	a_ctrl_write: assert property (ce && wr_en && wr_strb[0] && wr_idx == `CRR_IDX_CTRL |=>
		cross_listen_disable == $past(wr_data[`CRR_CTRL_XDIS_BIT]))
		else $error("cross listen control not written");

	a_status_held: assert property (!(ce && meas_done) |=> $stable(status_r))
		else $error("status changed without a measurement");

	// answers stand until the master takes them
	a_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped before it was taken");

	a_rvalid_hold: assert property (s_rvalid && !s_rready |=>
		s_rvalid && $stable(s_rdata) && $stable(s_rresp))
		else $error("read data dropped before it was taken");

	a_arready_low: assert property (s_rvalid |-> !s_arready)
		else $error("read address accepted while a read is pending");

	a_read_answer: assert property (ce && s_arvalid && s_arready |=> s_rvalid)
		else $error("read not answered in one cycle");

	a_write_answer: assert property (ce && wr_en |=> s_bvalid)
		else $error("write not answered in one cycle");

	// unmapped words answer with an error and zero data
	a_read_err: assert property (ce && s_arvalid && s_arready && !rd_hit |=>
		s_rresp == 2'b10 && s_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	a_write_err: assert property (ce && wr_en && !wr_hit |=> s_bresp == 2'b10)
		else $error("unmapped write not refused");

	a_result_upper: assert property (rd_idx >= `CRR_IDX_A01 && rd_idx <= `CRR_IDX_D34 |->
		rd_data[31:16] == 16'h0000 && rd_hit)
		else $error("result word upper half not zero");

endmodule // crr_top

/* bench/tb_crr_top.sv */
// testbench for the reflection result bank: axi4-lite register tests and measurement loads
// assumes crr_top with its default parameters and the register indices of crr_cfg.svh
`timescale 1ns/100ps
`include "crr_cfg.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("Error at %0t: got %h exp %h", $time, (got), (exp)); end end

module tb_crr_top
	import crr_pkg::*;
;
	logic mclk, rstn, ce;
	logic [11:0] s_awaddr, s_araddr;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	crr_word_t s_wdata, s_rdata, rd_d;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rd_r;
	logic meas_done, cross_listen_disable, irq;
	logic [159:0] peak_pos_in, pos;
	logic [3:0] cross_peak_in, count_full_in, first_seg_high_in;
	int err_total, n_tests, cyc;

	crr_top u_crr_top (.mclk(mclk), .rstn(rstn), .ce(ce), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .meas_done(meas_done), .peak_pos_in(peak_pos_in),
		.cross_peak_in(cross_peak_in), .count_full_in(count_full_in),
		.first_seg_high_in(first_seg_high_in), .cross_listen_disable(cross_listen_disable),
		.irq(irq));

	// ----------------------------------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// the whole run needs well under a thousand bus cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// bus tasks: entered just after a rising edge, handshakes sampled at the
	// falling edge where registered readies are settled, released after the edge
	// ----------------------------------------------------------------
	task automatic axw(input logic [9:0] idx, input crr_word_t d, input logic [3:0] st,
		output logic [1:0] r);
		logic ah, wh, bh, done;
		// one edge apart from the previous release, so no signal is driven twice at once
		@(posedge mclk);
		s_awaddr <= {idx, 2'b00};
		s_wdata <= d;
		s_wstrb <= st;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge mclk);
			ah = s_awvalid & s_awready;
			wh = s_wvalid & s_wready;
			bh = s_bvalid & s_bready;
			if (bh)
				r = s_bresp;
			@(posedge mclk);
			if (ah)
				s_awvalid <= 1'b0;
			if (wh)
				s_wvalid <= 1'b0;
			if (bh) begin
				s_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic axr(input logic [9:0] idx, output crr_word_t d, output logic [1:0] r);
		logic ah, rh, done;
		@(posedge mclk);
		s_araddr <= {idx, 2'b00};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge mclk);
			ah = s_arvalid & s_arready;
			rh = s_rvalid & s_rready;
			if (rh) begin
				d = s_rdata;
				r = s_rresp;
			end
			@(posedge mclk);
			if (ah)
				s_arvalid <= 1'b0;
			if (rh) begin
				s_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd_chk(input logic [9:0] idx, input crr_word_t exp);
		axr(idx, rd_d, rd_r);
		`CHK(rd_d, exp)
		`CHK(rd_r, 2'b00)
	endtask

	task automatic wr_chk(input logic [9:0] idx, input crr_word_t d, input logic [3:0] st,
		input logic [1:0] exp);
		axw(idx, d, st, rd_r);
		`CHK(rd_r, exp)
	endtask

	// ----------------------------------------------------------------
	// measurement helpers
	// ----------------------------------------------------------------
	function automatic logic [159:0] mkpos(input logic [7:0] b, input logic [7:0] s);
		logic [159:0] p;
		for (int k = 0; k < 20; k++)
			p[8*k +: 8] = 8'(b + 8'(k) * s);
		return p;
	endfunction

	// inputs are inverted right after the pulse so a bank that keeps sampling shows it
	task automatic meas(input logic [159:0] p, input logic [3:0] c, f, h);
		peak_pos_in <= p;
		cross_peak_in <= c;
		count_full_in <= f;
		first_seg_high_in <= h;
		meas_done <= 1'b1;
		@(posedge mclk);
		meas_done <= 1'b0;
		peak_pos_in <= ~p;
		cross_peak_in <= ~c;
		count_full_in <= ~f;
		first_seg_high_in <= ~h;
		@(posedge mclk);
	endtask

	// word i carries position 2i low and 2i+1 high, channel A first
	task automatic chk_pos(input logic [159:0] p);
		for (int i = 0; i < 10; i++)
			rd_chk(10'(`CRR_IDX_A01 + i), {16'h0000, p[16*i +: 16]});
	endtask

	// looked at mid-cycle, away from the edge that updates the output
	task automatic chk_out(ref logic got, input logic exp);
		@(negedge mclk);
		`CHK(got, exp)
		@(posedge mclk);
	endtask

	task automatic chk_zero();
		chk_pos(160'h0);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_0000);
		rd_chk(`CRR_IDX_CTRL, 32'h0000_0000);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0000);
		rd_chk(`CRR_IDX_IRQ_EN, 32'h0000_0000);
		chk_out(irq, 1'b0);
		chk_out(cross_listen_disable, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{s_awaddr, s_araddr, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		s_wdata = '0;
		s_wstrb = 4'h0;
		{meas_done, peak_pos_in, cross_peak_in, count_full_in, first_seg_high_in} = '0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk_zero();
		// writes to result and status registers are answered but change nothing
		wr_chk(`CRR_IDX_A01, 32'hffff_ffff, 4'hf, 2'b00);
		wr_chk(`CRR_IDX_STATUS, 32'hffff_ffff, 4'hf, 2'b00);
		rd_chk(`CRR_IDX_A01, 32'h0000_0000);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_0000);
		// unmapped index in both directions
		wr_chk(10'h1a0, 32'h0000_0001, 4'hf, 2'b10);
		axr(10'h1a0, rd_d, rd_r);
		`CHK(rd_d, 32'h0000_0000)
		`CHK(rd_r, 2'b10)
		// first run: all flag groups distinct, interrupts still masked
		pos = mkpos(8'h03, 8'h0d);
		meas(pos, 4'h5, 4'ha, 4'h3);
		chk_pos(pos);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_05a3);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0007);
		chk_out(irq, 1'b0);
		// second run replaces everything, field values reach 8'hff
		pos = mkpos(8'hff, 8'hf3);
		meas(pos, 4'ha, 4'h5, 4'hc);
		chk_pos(pos);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_0a5c);
		// interrupt: enable one source, clear it, then all of them
		wr_chk(`CRR_IDX_IRQ_EN, 32'h0000_0002, 4'hf, 2'b00);
		rd_chk(`CRR_IDX_IRQ_EN, 32'h0000_0002);
		chk_out(irq, 1'b1);
		wr_chk(`CRR_IDX_IRQ_CLR, 32'h0000_0002, 4'hf, 2'b00);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0005);
		chk_out(irq, 1'b0);
		rd_chk(`CRR_IDX_IRQ_CLR, 32'h0000_0000);
		wr_chk(`CRR_IDX_IRQ_EN, 32'h0000_0007, 4'hf, 2'b00);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0005);
		chk_out(irq, 1'b1);
		wr_chk(`CRR_IDX_IRQ_CLR, 32'h0000_0007, 4'hf, 2'b00);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0000);
		chk_out(irq, 1'b0);
		// cross listening off: a write without byte 0 strobe must not turn it back on
		wr_chk(`CRR_IDX_CTRL, 32'h0000_0001, 4'hf, 2'b00);
		wr_chk(`CRR_IDX_CTRL, 32'h0000_0000, 4'he, 2'b00);
		rd_chk(`CRR_IDX_CTRL, 32'h0000_0001);
		chk_out(cross_listen_disable, 1'b1);
		meas(pos, 4'hf, 4'h0, 4'h0);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_0000);
		rd_chk(`CRR_IDX_IRQ_STAT, 32'h0000_0001);
		chk_out(irq, 1'b1);
		wr_chk(`CRR_IDX_CTRL, 32'h0000_0000, 4'hf, 2'b00);
		meas(pos, 4'hf, 4'h0, 4'h0);
		rd_chk(`CRR_IDX_STATUS, 32'h0000_0f00);
		// reset in mid-run wipes results, flags and control
		wr_chk(`CRR_IDX_CTRL, 32'h0000_0001, 4'hf, 2'b00);
		rstn <= 1'b0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk_zero();
		final_report();
	end

endmodule // tb_crr_top
